//--- logic/dtw_top.sv
// Dead-time waveform extension: complementary outputs, pattern generator, fault unit
`timescale 1ns/1ps
`default_nettype none

module dtw_top
  import dtw_pkg::*;
#(
  parameter int N_CH          = 4,
  parameter int EV_W          = 8,
  parameter bit FLAWED_RESTORE = 1'b0
)
(
  input  wire logic              ref_clk,
  input  wire logic              rst,
  input  wire logic [DTW_AW-1:0] addr,
  input  wire logic [DTW_DW-1:0] wdata,
  input  wire logic              wr,
  input  wire logic              rd,
  output logic      [DTW_DW-1:0] rdata,
  input  wire logic              tc_wg_mode,
  input  wire logic [N_CH-1:0]   tc_wg,
  input  wire logic              tc_update,
  output logic                   tc_halt,
  input  wire logic [EV_W-1:0]   events,
  input  wire logic [2*N_CH-1:0] port_out_normal,
  output logic      [2*N_CH-1:0] pin_out,
  output logic                   irq
);

  localparam int PINS = 2 * N_CH;

  if (N_CH != 4 || EV_W < 1 || EV_W > DTW_DW)
  begin : g_bad_param
    $error("dtw_top: four channels and one to eight event lines are supported");
  end

  // Pin 2i carries the low side of channel i, pin 2i+1 the high side
  function automatic logic [PINS-1:0] pair_mask(input logic [N_CH-1:0] en);
    logic [PINS-1:0] m;
    m = '0;
    for (int i = 0; i < N_CH; i++)
    begin
      m[2*i]   = en[i];
      m[2*i+1] = en[i];
    end
    return m;
  endfunction

  function automatic logic hit(input logic [DTW_AW-1:0] a, input logic [DTW_AW-1:0] r);
    return a == r;
  endfunction

  logic [DTW_DW-1:0] ctrl;
  logic [DTW_DW-1:0] flt_ctrl;
  logic [DTW_DW-1:0] status;
  logic [DTW_DW-1:0] int_mask;
  logic [DTW_DW-1:0] dt_ls_buf;
  logic [DTW_DW-1:0] dt_hs_buf;
  logic [DTW_DW-1:0] dt_ls;
  logic [DTW_DW-1:0] dt_hs;
  logic [PINS-1:0]   ovr_en;
  logic [PINS-1:0]   pat_buf;
  logic [EV_W-1:0]   ev_sel;
  logic              dt_bv;
  logic              pat_bv;
  dtw_flt_e          flt_state;
  dtw_flt_e          next_flt_state;

  logic [DTW_DW-1:0] dt_cnt  [N_CH];
  logic [N_CH-1:0]   wg_prev;

  // Decoding
  wire logic [N_CH-1:0] dti_en    = ctrl[DTW_C_DTI_LSB +: N_CH];
  wire logic            pattern_generation_mode       = ctrl[DTW_C_PGM];
  wire logic            common_waveform_channel_mode      = ctrl[DTW_C_COMMON_WAVEFORM_CHANNEL_MODE];
  wire logic            halt_en   = ctrl[DTW_C_HALT];
  wire logic            any_feat  = (|dti_en) | pattern_generation_mode | common_waveform_channel_mode;
  wire logic            active    = tc_wg_mode & any_feat;
  wire logic            fault_evt = |(events & ev_sel);
  wire logic            wr_ctrl   = wr & hit(addr, DTW_A_CTRL);
  wire logic            wr_flt    = wr & hit(addr, DTW_A_FLT_CTRL);
  wire logic            wr_stat   = wr & hit(addr, DTW_A_STATUS);
  wire logic            wr_mask   = wr & hit(addr, DTW_A_INT_MASK);
  wire logic            wr_dtls   = wr & hit(addr, DTW_A_DT_LS_BUF);
  wire logic            wr_dths   = wr & hit(addr, DTW_A_DT_HS_BUF);
  wire logic            wr_ovr    = wr & hit(addr, DTW_A_OVR_EN);
  wire logic            wr_pat    = wr & hit(addr, DTW_A_PAT_BUF);
  wire logic            wr_evs    = wr & hit(addr, DTW_A_EV_SEL);
  wire logic            flt_clr   = wr_flt & wdata[DTW_F_CLEAR];
  wire logic            latched   = flt_ctrl[DTW_F_LATCH];
  wire logic            in_fault  = flt_state != DTW_FLT_OK;
  wire logic            dt_load   = tc_update & dt_bv;
  wire logic            pat_load  = tc_update & pat_bv & pattern_generation_mode;

  // Restore mapping; the flawed option reproduces older silicon for software tests
  wire logic [PINS-1:0] restore_val = (pattern_generation_mode && !FLAWED_RESTORE) ? pat_buf
                                                               : pair_mask(dti_en);

  // Per-channel waveform source and dead-time state
  logic [N_CH-1:0] wg_src;
  logic [N_CH-1:0] dead;
  logic [N_CH-1:0] ls_o;
  logic [N_CH-1:0] hs_o;
  always_comb
  begin
    for (int i = 0; i < N_CH; i++)
    begin
      wg_src[i] = common_waveform_channel_mode ? tc_wg[0] : tc_wg[i];
      dead[i]   = (dt_cnt[i] != DTW_RST_ZERO) | (wg_src[i] != wg_prev[i]);
      ls_o[i]   = wg_prev[i] & ~dead[i];
      hs_o[i]   = ~wg_prev[i] & ~dead[i];
    end
  end

  // Output value per pin: pattern mode spreads channel A, else inserter pairs
  logic [PINS-1:0] ext_val;
  always_comb
  begin
    for (int i = 0; i < N_CH; i++)
    begin
      ext_val[2*i]   = pattern_generation_mode ? tc_wg[0] : ls_o[i];
      ext_val[2*i+1] = pattern_generation_mode ? tc_wg[0] : hs_o[i];
    end
  end

  // Override held off whenever a fault is present, even in the cycle it arrives
  wire logic [PINS-1:0] ovr_live  = (active && !in_fault && !fault_evt) ? ovr_en : '0;
  wire logic [PINS-1:0] next_pins = (ovr_live & ext_val) | (~ovr_live & port_out_normal);

  assign tc_halt = halt_en & active & (|dead) & ~pattern_generation_mode;
  assign irq     = |(status & int_mask);

  // Fault sequencing
  always_comb
  begin
    next_flt_state = flt_state;
    case (flt_state)
      DTW_FLT_OK:
        if (fault_evt)
          next_flt_state = DTW_FLT_HOLD;
      DTW_FLT_HOLD:
        if (!fault_evt && (!latched || flt_clr))
          next_flt_state = DTW_FLT_RESTORE;
      DTW_FLT_RESTORE:
        next_flt_state = fault_evt ? DTW_FLT_HOLD : DTW_FLT_OK;
      default:
        next_flt_state = DTW_FLT_HOLD;
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      flt_state <= DTW_FLT_HOLD;
    else
      flt_state <= next_flt_state;
  end

  // Override enable: fault clears it, restore reloads it, pattern update loads it
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      ovr_en <= '0;
    else if (fault_evt || flt_state == DTW_FLT_HOLD)
      ovr_en <= '0;
    else if (flt_state == DTW_FLT_RESTORE)
      ovr_en <= restore_val;
    else if (wr_ovr)
      ovr_en <= wdata[PINS-1:0];
    else if (pat_load)
      ovr_en <= pat_buf;
  end

  // Control registers
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      ctrl     <= DTW_RST_ZERO;
      flt_ctrl <= DTW_RST_ZERO;
      int_mask <= DTW_RST_ZERO;
      ev_sel   <= '0;
    end
    else
    begin
      if (wr_ctrl)
        ctrl <= wdata;
      if (wr_flt)
        flt_ctrl <= {wdata[DTW_DW-1:DTW_F_CLEAR+1], 1'b0, wdata[DTW_F_LATCH]};
      if (wr_mask)
        int_mask <= wdata;
      if (wr_evs)
        ev_sel <= wdata[EV_W-1:0];
    end
  end

  // Double buffers; working dead time moves only on the timer update
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      dt_ls_buf <= DTW_DT_ONE;
      dt_hs_buf <= DTW_DT_ONE;
      dt_ls     <= DTW_DT_ONE;
      dt_hs     <= DTW_DT_ONE;
      pat_buf   <= '0;
      dt_bv     <= 1'b0;
      pat_bv    <= 1'b0;
    end
    else
    begin
      if (wr_dtls)
        dt_ls_buf <= wdata;
      if (wr_dths)
        dt_hs_buf <= wdata;
      if (dt_load)
      begin
        dt_ls <= dt_ls_buf;
        dt_hs <= dt_hs_buf;
      end
      dt_bv <= (wr_dtls | wr_dths) | (dt_bv & ~tc_update);
      if (wr_pat)
        pat_buf <= wdata[PINS-1:0];
      pat_bv <= wr_pat | (pat_bv & ~pat_load);
    end
  end

  // Dead-time counters, one per channel
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      wg_prev <= '0;
      for (int i = 0; i < N_CH; i++)
        dt_cnt[i] <= DTW_RST_ZERO;
    end
    else
    begin
      for (int i = 0; i < N_CH; i++)
      begin
        if (wg_src[i] != wg_prev[i])
        begin
          wg_prev[i] <= wg_src[i];
          dt_cnt[i]  <= wg_src[i] ? dt_ls : dt_hs;
        end
        else if (dt_cnt[i] != DTW_RST_ZERO)
          dt_cnt[i] <= dt_cnt[i] - DTW_DT_ONE;
      end
    end
  end

  // Sticky status; a new event wins over a same-cycle write-one clear
  wire logic [DTW_DW-1:0] ev_set = (DTW_DW'(fault_evt & ~in_fault) << DTW_S_FAULT)
                                 | (DTW_DW'(dt_load) << DTW_S_DT_UPD)
                                 | (DTW_DW'(pat_load) << DTW_S_PAT_UPD);
  wire logic [DTW_DW-1:0] stat_clr = wr_stat ? wdata : DTW_RST_ZERO;

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      status <= DTW_RST_ZERO;
    else
      status <= (status & ~stat_clr) | ev_set;
  end

  // Live state for software
  wire logic [DTW_DW-1:0] state_val = (DTW_DW'(in_fault) << DTW_T_FAULT)
                                    | (DTW_DW'(|dead) << DTW_T_DEAD)
                                    | (DTW_DW'(dt_bv) << DTW_T_DTBV)
                                    | (DTW_DW'(pat_bv) << DTW_T_PATBV);

  logic [DTW_DW-1:0] rd_mux;
  always_comb
  begin
    case (addr)
      DTW_A_CTRL:      rd_mux = ctrl;
      DTW_A_FLT_CTRL:  rd_mux = flt_ctrl;
      DTW_A_STATUS:    rd_mux = status;
      DTW_A_INT_MASK:  rd_mux = int_mask;
      DTW_A_DT_LS_BUF: rd_mux = dt_ls_buf;
      DTW_A_DT_HS_BUF: rd_mux = dt_hs_buf;
      DTW_A_OVR_EN:    rd_mux = DTW_DW'(ovr_en);
      DTW_A_PAT_BUF:   rd_mux = DTW_DW'(pat_buf);
      DTW_A_DT_LS:     rd_mux = dt_ls;
      DTW_A_DT_HS:     rd_mux = dt_hs;
      DTW_A_EV_SEL:    rd_mux = DTW_DW'(ev_sel);
      DTW_A_STATE:     rd_mux = state_val;
      default:         rd_mux = DTW_RST_ZERO;
    endcase
  end

  // Read data and pins come from flip-flops
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      rdata   <= DTW_RST_ZERO;
      pin_out <= '0;
    end
    else
    begin
      rdata   <= rd ? rd_mux : DTW_RST_ZERO;
      pin_out <= next_pins;
    end
  end

endmodule

`default_nettype wire

//--- shared/dtw_pkg.sv
// Register map, field positions and state codes for the dead-time waveform extension
package dtw_pkg;

  localparam int DTW_AW = 4;
  localparam int DTW_DW = 8;

  // Register addresses
  localparam logic [3:0] DTW_A_CTRL      = 4'h0;
  localparam logic [3:0] DTW_A_FLT_CTRL  = 4'h1;
  localparam logic [3:0] DTW_A_STATUS    = 4'h2;
  localparam logic [3:0] DTW_A_INT_MASK  = 4'h3;
  localparam logic [3:0] DTW_A_DT_LS_BUF = 4'h4;
  localparam logic [3:0] DTW_A_DT_HS_BUF = 4'h5;
  localparam logic [3:0] DTW_A_OVR_EN    = 4'h6;
  localparam logic [3:0] DTW_A_PAT_BUF   = 4'h7;
  localparam logic [3:0] DTW_A_DT_LS     = 4'h8;
  localparam logic [3:0] DTW_A_DT_HS     = 4'h9;
  localparam logic [3:0] DTW_A_EV_SEL    = 4'hA;
  localparam logic [3:0] DTW_A_STATE     = 4'hB;

  // Control register fields
  localparam int DTW_C_DTI_LSB = 0;
  localparam int DTW_C_PGM     = 4;
  localparam int DTW_C_COMMON_WAVEFORM_CHANNEL_MODE    = 5;
  localparam int DTW_C_HALT    = 6;

  // Fault control fields
  localparam int DTW_F_LATCH = 0;
  localparam int DTW_F_CLEAR = 1;

  // Status and interrupt mask fields
  localparam int DTW_S_FAULT = 0;
  localparam int DTW_S_DT_UPD  = 1;
  localparam int DTW_S_PAT_UPD = 2;

  // Live state fields
  localparam int DTW_T_FAULT = 0;
  localparam int DTW_T_DEAD  = 1;
  localparam int DTW_T_DTBV  = 2;
  localparam int DTW_T_PATBV = 3;

  // Reset values
  localparam logic [7:0] DTW_RST_ZERO = 8'h00;
  localparam logic [7:0] DTW_DT_ONE   = 8'h01;

  typedef enum logic [2:0]
  {
    DTW_FLT_OK      = 3'b001,
    DTW_FLT_HOLD    = 3'b010,
    DTW_FLT_RESTORE = 3'b100
  } dtw_flt_e;

endpackage

//--- bench/dtw_chk.sv
// Port-level assertions for the dead-time waveform extension
`timescale 1ns/1ps
`default_nettype none
module dtw_chk
  import dtw_pkg::*;
#(
  parameter int N_CH           = 4,
  parameter int EV_W           = 8,
  parameter bit FLAWED_RESTORE = 1'b0
)
(
  input wire logic              ref_clk,
  input wire logic              rst,
  input wire logic [DTW_AW-1:0] addr,
  input wire logic [DTW_DW-1:0] wdata,
  input wire logic              wr,
  input wire logic              rd,
  input wire logic [DTW_DW-1:0] rdata,
  input wire logic              tc_wg_mode,
  input wire logic [N_CH-1:0]   tc_wg,
  input wire logic              tc_update,
  input wire logic              tc_halt,
  input wire logic [EV_W-1:0]   events,
  input wire logic [2*N_CH-1:0] port_out_normal,
  input wire logic [2*N_CH-1:0] pin_out,
  input wire logic              irq
);
  logic [DTW_DW-1:0] mask_q;
  logic [DTW_DW-1:0] ctrl_q;
  logic [EV_W-1:0]   sel_q;
  logic              live;
  function automatic logic clash(logic [2*N_CH-1:0] p, logic [2*N_CH-1:0] n);
    for (int i = 0; i < N_CH; i++)
      if (p[2*i] && p[2*i+1] && !n[2*i] && !n[2*i+1])
        return 1'b1;
    return 1'b0;
  endfunction
  // Shadows rebuilt from bus writes, since no internal state is visible here
  always_ff @(posedge ref_clk or posedge rst)
    if (rst) mask_q <= '0;
    else if (wr && addr == DTW_A_INT_MASK) mask_q <= wdata;
  always_ff @(posedge ref_clk or posedge rst)
    if (rst) ctrl_q <= '0;
    else if (wr && addr == DTW_A_CTRL) ctrl_q <= wdata;
  always_ff @(posedge ref_clk or posedge rst)
    if (rst) sel_q <= '0;
    else if (wr && addr == DTW_A_EV_SEL) sel_q <= EV_W'(wdata);
  // Masks the first edge after reset, where $past still sees reset values
  always_ff @(posedge ref_clk or posedge rst)
    if (rst) live <= 1'b0;
    else live <= 1'b1;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  a_rd_idle_zero: assert property (!rd |=> rdata == '0)
    else $error("read data not zero outside an answer");
  a_unmapped_zero: assert property (rd && addr > DTW_A_STATE |=> rdata == '0)
    else $error("unmapped read not zero");
  a_normal_pass:
    assert property (live && !tc_wg_mode |=> pin_out == $past(port_out_normal))
    else $error("pins not normal outside waveform mode");
  a_fault_pass:
    assert property (live && |(events & sel_q) |=> pin_out == $past(port_out_normal))
    else $error("pins still overridden during fault");
  a_no_overlap:
    assert property (live && !ctrl_q[DTW_C_PGM] && !$past(ctrl_q[DTW_C_PGM])
      |-> !clash(pin_out, $past(port_out_normal)))
    else $error("both sides of a pair on");
  a_halt_mode:
    assert property (tc_halt |-> ctrl_q[DTW_C_HALT] && !ctrl_q[DTW_C_PGM])
    else $error("halt without halt enable or in pattern mode");
  a_irq_masked: assert property (irq |-> |mask_q[2:0])
    else $error("interrupt with all sources masked");
  a_irq_fault:
    assert property (live && |(events & sel_q) && mask_q[DTW_S_FAULT] |-> ##[1:2] irq)
    else $error("fault did not raise the interrupt");
  c_halt: cover property (tc_halt);
  c_fault: cover property (|(events & sel_q));
  c_dt_read: cover property (rd && addr == DTW_A_DT_LS);
endmodule
bind dtw_top dtw_chk #(.N_CH(N_CH), .EV_W(EV_W), .FLAWED_RESTORE(FLAWED_RESTORE)) u_chk
(
  .ref_clk(ref_clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .rdata(rdata), .tc_wg_mode(tc_wg_mode), .tc_wg(tc_wg), .tc_update(tc_update),
  .tc_halt(tc_halt), .events(events), .port_out_normal(port_out_normal),
  .pin_out(pin_out), .irq(irq)
);
`default_nettype wire

//--- bench/dtw_stage_mdl.sv
// Power stage model: reports a desaturation fault when the bench commands one
`timescale 1ns/1ps
`default_nettype none
module dtw_stage_mdl
(
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic [7:0] pin_out,
  input  wire logic       trip,
  output logic            fault_ev
);
  // Registered like a real sense comparator, so the fault lags the cause by one cycle
  always_ff @(posedge ref_clk or posedge rst)
    if (rst) fault_ev <= 1'b0;
    else fault_ev <= trip;
endmodule
`default_nettype wire

//--- bench/dead_time_waveform_extension_tb_top.sv
// Self-checking bench for the dead-time waveform extension
`timescale 1ns/1ps
`default_nettype none
module dead_time_waveform_extension_tb_top;
  import dtw_pkg::*;
  logic       ref_clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, tc_update = 1'b0;
  logic       tc_wg_mode = 1'b0, trip = 1'b0, tc_halt, irq, fault_ev, halt_seen;
  logic [3:0] addr = '0, tc_wg = '0;
  logic [7:0] wdata = '0, normal = '0, ev = '0, ov, rdata, pin_out;
  int         err_total = 0, num_checks = 0, n;
  integer     seed = 32'hd43c_5560;
  dtw_top u_dut
  (
    .ref_clk(ref_clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .tc_wg_mode(tc_wg_mode), .tc_wg(tc_wg), .tc_update(tc_update),
    .tc_halt(tc_halt), .events({ev[7:1], fault_ev}), .port_out_normal(normal),
    .pin_out(pin_out), .irq(irq)
  );
  dtw_stage_mdl u_stage
  (
    .ref_clk(ref_clk), .rst(rst), .pin_out(pin_out), .trip(trip), .fault_ev(fault_ev)
  );
  always #12.5 ref_clk = ~ref_clk;
  // Expected pins: mode 0 per channel, 1 channel A to all pairs, 2 pattern
  function automatic logic [7:0] pins(logic [3:0] w, logic [7:0] o, int m);
    logic [7:0] p;
    for (int i = 0; i < 4; i++)
      p[2*i +: 2] = (m == 2) ? {2{w[0]}} : (m == 1) ? {~w[0], w[0]} : {~w[i], w[i]};
    return (p & o) | (normal & ~o);
  endfunction
  task automatic chk(string what, logic [7:0] seen, logic [7:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wreg(logic [3:0] a, logic [7:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(logic [3:0] a, logic [7:0] exp, string what);
    @(posedge ref_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    @(negedge ref_clk);
    chk(what, rdata, exp);
  endtask
  task automatic tick(int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask
  task automatic fault_pulse();
    @(posedge ref_clk);
    trip <= 1'b1;
    repeat (3) @(posedge ref_clk);
    trip <= 1'b0;
    #1;
  endtask
  // Counts edges from a source change until the turning-on side appears
  task automatic dt_edge(logic v, int dt, int p);
    @(posedge ref_clk);
    tc_wg[0] <= v;
    n = 0;
    halt_seen = 1'b0;
    while (pin_out[p] !== 1'b1 && n < 300)
    begin
      tick(1);
      n++;
      halt_seen |= tc_halt;
    end
    chk("dead_cycles", 8'(n > dt && n < dt + 5), 8'h01);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    #100us;
    err_total++;
    $display("mismatch watchdog expected done seen timeout");
    stop_test();
  end
  initial
  begin
    tick(16);
    rst <= 1'b0;
    rreg(DTW_A_DT_LS, DTW_DT_ONE, "dt_ls_reset");
    rreg(DTW_A_DT_HS, DTW_DT_ONE, "dt_hs_reset");
    for (int a = 12; a < 16; a++)
      rreg(4'(a), DTW_RST_ZERO, "unmapped");
    @(posedge ref_clk);
    normal <= 8'($random(seed));
    ev <= 8'($random(seed));
    tc_wg <= 4'($random(seed));
    tick(3);
    chk("normal_pins", pin_out, normal);
    $display("test reset and pass-through done");
    wreg(DTW_A_DT_LS_BUF, 8'h03);
    wreg(DTW_A_DT_HS_BUF, 8'h05);
    rreg(DTW_A_DT_LS, DTW_DT_ONE, "dt_ls_held");
    @(posedge ref_clk);
    tc_update <= 1'b1;
    @(posedge ref_clk);
    tc_update <= 1'b0;
    rreg(DTW_A_DT_LS, 8'h03, "dt_ls_loaded");
    rreg(DTW_A_DT_HS, 8'h05, "dt_hs_loaded");
    wreg(DTW_A_CTRL, 8'h4f);
    wreg(DTW_A_OVR_EN, 8'hff);
    tc_wg_mode <= 1'b1;
    tc_wg <= 4'h0;
    tick(10);
    dt_edge(1'b1, 3, 0);
    chk("halt", {7'h0, halt_seen}, 8'h01);
    dt_edge(1'b0, 5, 1);
    for (int k = 0; k < 3; k++)
    begin
      ov = 8'($random(seed));
      wreg(DTW_A_CTRL, (k == 2) ? 8'h6f : 8'h4f);
      wreg(DTW_A_OVR_EN, ov);
      tc_wg <= 4'($random(seed));
      tick(14);
      chk("pairs", pin_out, pins(tc_wg, ov, (k == 2) ? 1 : 0));
    end
    $display("test dead time done");
    wreg(DTW_A_OVR_EN, 8'hff);
    wreg(DTW_A_EV_SEL, 8'h01);
    wreg(DTW_A_INT_MASK, 8'h01);
    wreg(DTW_A_FLT_CTRL, 8'h01);
    fault_pulse();
    chk("fault_pins", pin_out, normal);
    chk("fault_irq", {7'h0, irq}, 8'h01);
    tick(4);
    rreg(DTW_A_OVR_EN, 8'h00, "ovr_cleared");
    wreg(DTW_A_OVR_EN, 8'h3c);
    rreg(DTW_A_OVR_EN, 8'h00, "ovr_held");
    wreg(DTW_A_FLT_CTRL, 8'h03);
    tick(4);
    rreg(DTW_A_OVR_EN, 8'hff, "ovr_restored");
    wreg(DTW_A_STATUS, 8'h01);
    #1;
    chk("irq_clear", {7'h0, irq}, 8'h00);
    $display("test fault done");
    wreg(DTW_A_FLT_CTRL, 8'h00);
    wreg(DTW_A_CTRL, 8'h5f);
    wreg(DTW_A_PAT_BUF, 8'ha5);
    @(posedge ref_clk);
    tc_update <= 1'b1;
    @(posedge ref_clk);
    tc_update <= 1'b0;
    rreg(DTW_A_OVR_EN, 8'ha5, "pattern_loaded");
    repeat (2)
    begin
      @(posedge ref_clk);
      tc_wg <= 4'($random(seed));
      tick(6);
      chk("pattern_pins", pin_out, pins(tc_wg, 8'ha5, 2));
    end
    fault_pulse();
    tick(8);
    rreg(DTW_A_OVR_EN, 8'ha5, "pattern_restore");
    // Latched pattern fault left the way software must do it on older parts
    wreg(DTW_A_FLT_CTRL, 8'h01);
    fault_pulse();
    tick(4);
    wreg(DTW_A_CTRL, 8'h50);
    wreg(DTW_A_FLT_CTRL, 8'h03);
    wreg(DTW_A_OVR_EN, 8'h5a);
    wreg(DTW_A_CTRL, 8'h5f);
    rreg(DTW_A_OVR_EN, 8'h5a, "sw_restore");
    $display("test pattern done");
    stop_test();
  end
endmodule
`default_nettype wire
